// *** logic/ofc_consts.svh ***
/*
 Constants of the operand format classifier: field positions, biases, codes.
 Assumes it is included by bare name from the package and the design modules.
*/
//
// Contract
// - Integers are widened to extended precision before floating-point use.
// - Single real is 32 bits: sign, 8-bit exponent, 23-bit fraction.
// - Double real is 64 bits: sign, 11-bit exponent, 52-bit fraction.
// - Extended real is 80 bits: sign, 15-bit exponent, 64-bit mantissa.
// - Packed decimal real raises unimplemented-format trap, not illegal instruction.
// - Every real operand but packed decimal is classed as exactly one of five types.
// - The 128-bit block operand comes only from memory, 16-byte aligned.
// - Decimal bytes hold two digits packed or one digit unpacked.
// - Bit fields are runs of consecutive bits, one to thirty-two long.
// - Quad-word integers of 64 bits sit in any pair of data registers.
// - Byte, word and long-word integers are 8, 16 and 32 bits.
`ifndef OFC_CONSTS_SVH
`define OFC_CONSTS_SVH

`define OFC_SGL_EXP_MSB 30
`define OFC_SGL_EXP_LSB 23
`define OFC_DBL_EXP_MSB 62
`define OFC_DBL_EXP_LSB 52
`define OFC_EXT_EXP_MSB 78
`define OFC_EXT_EXP_LSB 64
`define OFC_EXT_EXP_MAX 15'h7fff
`define OFC_SGL_REBIAS 15'h3f80
`define OFC_DBL_REBIAS 15'h3c00
`define OFC_SGL_DEN_EXP 15'h3f81
`define OFC_DBL_DEN_EXP 15'h3c01
`define OFC_INT_EXP_BASE 15'h401e
`define OFC_BLOCK_ALIGN_MASK 32'h0000_000f
`define OFC_BCD_DIGIT_MAX 4'h9

`endif

// *** logic/ofc_pkg.sv ***
/*
 Types shared by the operand format classifier modules.
 Assumes the constants header is on the include path.
*/
`include "ofc_consts.svh"
package ofc_pkg;

  typedef enum logic [3:0] {
    FMT_BYTE = 4'h0, FMT_WORD = 4'h1, FMT_LONG = 4'h2, FMT_SINGLE = 4'h3,
    FMT_DOUBLE = 4'h4, FMT_EXT = 4'h5, FMT_PACKED = 4'h6, FMT_BITFIELD = 4'h7,
    FMT_BCD_PACKED = 4'h8, FMT_BCD_UNPACKED = 4'h9, FMT_QUAD = 4'ha, FMT_BLOCK = 4'hb
  } ofc_fmt_e;

  // One-hot class; none only for operands that never reach floating point.
  typedef enum logic [4:0] {
    CLS_NONE = 5'h00, CLS_NORM = 5'h01, CLS_DENORM = 5'h02, CLS_ZERO = 5'h04,
    CLS_INF = 5'h08, CLS_NAN = 5'h10
  } ofc_cls_e;

  typedef struct packed {
    logic valid;
    ofc_fmt_e fmt;
    logic [127:0] data;
    logic from_mem;
    logic [31:0] addr;
    logic [4:0] bf_offset;
    logic [4:0] bf_width;
    logic [2:0] pair_hi;
    logic [2:0] pair_lo;
  } ofc_req_s;

  typedef struct packed {
    logic sign;
    logic [14:0] exp;
    logic [63:0] mant;
    ofc_cls_e cls;
  } ofc_fp_s;

  typedef struct packed {
    logic valid;
    ofc_fmt_e fmt;
    ofc_fp_s fp;
    logic [63:0] int_data;
    logic [127:0] blk_data;
    logic [2:0] pair_hi;
    logic [2:0] pair_lo;
    logic trap_unimp;
    logic trap_align;
    logic bcd_bad;
  } ofc_res_s;

  function automatic ofc_cls_e ofc_classify(input logic exp_zero, input logic exp_ones,
                                            input logic frac_zero);
    if (exp_zero) begin
      ofc_classify = frac_zero ? CLS_ZERO : CLS_DENORM;
    end else if (exp_ones) begin
      ofc_classify = frac_zero ? CLS_INF : CLS_NAN;
    end else begin
      ofc_classify = CLS_NORM;
    end
  endfunction : ofc_classify

endpackage : ofc_pkg

// *** logic/ofc_fp_unpack.sv ***
/*
 Combinational unpacker of single, double and extended reals into extended fields.
 Assumes the caller registers the result.
*/
`timescale 1ns/100ps
`include "ofc_consts.svh"
module ofc_fp_unpack (
  input wire ofc_pkg::ofc_fmt_e fmt,
  input wire logic [79:0] data,
  output ofc_pkg::ofc_fp_s fp
);

  logic [7:0] s_exp;
  logic [22:0] s_frac;
  logic [10:0] d_exp;
  logic [51:0] d_frac;
  logic [14:0] x_exp;

  assign s_exp = data[`OFC_SGL_EXP_MSB:`OFC_SGL_EXP_LSB];
  assign s_frac = data[22:0];
  assign d_exp = data[`OFC_DBL_EXP_MSB:`OFC_DBL_EXP_LSB];
  assign d_frac = data[51:0];
  assign x_exp = data[`OFC_EXT_EXP_MSB:`OFC_EXT_EXP_LSB];

  ////////////////////////////////////////////////////////////////////////////////
  // Denormals of the short formats keep a clear integer bit at the smallest exponent,
  // because extended precision may carry unnormalised mantissas.
  always_comb begin
    fp = '0;
    case (fmt)
      ofc_pkg::FMT_SINGLE: begin
        fp.sign = data[31];
        fp.cls = ofc_pkg::ofc_classify(s_exp == 8'h00, &s_exp, s_frac == 23'h00_0000);
        fp.mant = {s_exp != 8'h00, s_frac, 40'h00_0000_0000};
        if (s_exp == 8'h00) begin
          fp.exp = (s_frac == 23'h00_0000) ? 15'h0000 : `OFC_SGL_DEN_EXP;
        end else if (&s_exp) begin
          fp.exp = `OFC_EXT_EXP_MAX;
        end else begin
          fp.exp = {7'h00, s_exp} + `OFC_SGL_REBIAS;
        end
      end
      ofc_pkg::FMT_DOUBLE: begin
        fp.sign = data[63];
        fp.cls = ofc_pkg::ofc_classify(d_exp == 11'h000, &d_exp, d_frac == 52'h0);
        fp.mant = {d_exp != 11'h000, d_frac, 11'h000};
        if (d_exp == 11'h000) begin
          fp.exp = (d_frac == 52'h0) ? 15'h0000 : `OFC_DBL_DEN_EXP;
        end else if (&d_exp) begin
          fp.exp = `OFC_EXT_EXP_MAX;
        end else begin
          fp.exp = {4'h0, d_exp} + `OFC_DBL_REBIAS;
        end
      end
      ofc_pkg::FMT_EXT: begin
        fp.sign = data[79];
        fp.exp = x_exp;
        fp.mant = data[63:0];
        // The explicit integer bit does not take part in telling infinity from NaN.
        fp.cls = ofc_pkg::ofc_classify(x_exp == 15'h0000, &x_exp,
                                       (x_exp == `OFC_EXT_EXP_MAX) ? (data[62:0] == 63'h0)
                                       : (data[63:0] == 64'h0));
      end
      default: begin
        fp = '0;
      end
    endcase
  end

endmodule : ofc_fp_unpack

// *** logic/operand_format_classifier.sv ***
/*
 Operand format classifier: unpacks, widens and checks one operand per cycle.
 Assumes the pipeline presents requests synchronous to sys_clk and reads the
 registered result one enabled edge later; no back-pressure is offered.
*/
`timescale 1ns/100ps
`include "ofc_consts.svh"
module operand_format_classifier (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire ofc_pkg::ofc_req_s req,
  output ofc_pkg::ofc_res_s res
);

  typedef struct packed {
    ofc_pkg::ofc_res_s res;
  } ofc_state_s;

  ofc_state_s state;
  ofc_state_s next_state;
  logic rst_meta;
  logic rst_sync_n;
  ofc_pkg::ofc_fp_s real_fp;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops so no flop leaves reset on a ragged edge.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  ofc_fp_unpack u_fp_unpack (
    .fmt(req.fmt),
    .data(req.data[79:0]),
    .fp(real_fp)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Integer widening: magnitude, leading-zero count, normalising shift.
  function automatic ofc_pkg::ofc_fp_s int_to_ext(input logic [31:0] v);
    logic [31:0] mag;
    logic [4:0] lz;
    logic found;
    int_to_ext = '0;
    mag = v[31] ? (32'h0000_0000 - v) : v;
    lz = 5'h00;
    found = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!found && mag[i]) begin
        found = 1'b1;
        lz = 5'(31 - i);
      end
    end
    int_to_ext.sign = v[31];
    if (mag == 32'h0000_0000) begin
      int_to_ext.cls = ofc_pkg::CLS_ZERO;
    end else begin
      int_to_ext.cls = ofc_pkg::CLS_NORM;
      int_to_ext.exp = `OFC_INT_EXP_BASE - {10'h000, lz};
      int_to_ext.mant = {mag << lz, 32'h0000_0000};
    end
  endfunction : int_to_ext

  function automatic logic bcd_digit_bad(input logic [3:0] d);
    bcd_digit_bad = d > `OFC_BCD_DIGIT_MAX;
  endfunction : bcd_digit_bad

  ////////////////////////////////////////////////////////////////////////////////
  // Bit field: offset counts from the msb of the upper long word; a width code of
  // zero stands for thirty-two bits, so every length from one to thirty-two fits.
  function automatic logic [31:0] field_extract(input logic [63:0] win, input logic [4:0] off,
                                                input logic [4:0] wcode);
    logic [5:0] len;
    logic [63:0] shifted;
    logic [31:0] mask;
    len = (wcode == 5'h00) ? 6'h20 : {1'b0, wcode};
    shifted = (win << off) >> (7'd64 - {1'b0, len});
    mask = (len == 6'h20) ? 32'hffff_ffff : ((32'h0000_0001 << len) - 32'h0000_0001);
    field_extract = shifted[31:0] & mask;
  endfunction : field_extract

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_state.res.valid = req.valid;
    if (req.valid) begin
      next_state.res = '0;
      next_state.res.valid = 1'b1;
      next_state.res.fmt = req.fmt;
      case (req.fmt)
        ofc_pkg::FMT_BYTE: begin
          next_state.res.int_data = {{56{req.data[7]}}, req.data[7:0]};
          next_state.res.fp = int_to_ext({{24{req.data[7]}}, req.data[7:0]});
        end
        ofc_pkg::FMT_WORD: begin
          next_state.res.int_data = {{48{req.data[15]}}, req.data[15:0]};
          next_state.res.fp = int_to_ext({{16{req.data[15]}}, req.data[15:0]});
        end
        ofc_pkg::FMT_LONG: begin
          next_state.res.int_data = {{32{req.data[31]}}, req.data[31:0]};
          next_state.res.fp = int_to_ext(req.data[31:0]);
        end
        ofc_pkg::FMT_SINGLE, ofc_pkg::FMT_DOUBLE, ofc_pkg::FMT_EXT: begin
          next_state.res.fp = real_fp;
        end
        ofc_pkg::FMT_PACKED: begin
          // Nothing is decoded; software emulates the whole operation.
          next_state.res.trap_unimp = 1'b1;
        end
        ofc_pkg::FMT_BITFIELD: begin
          next_state.res.int_data = {32'h0000_0000,
                                     field_extract(req.data[63:0], req.bf_offset,
                                                   req.bf_width)};
        end
        ofc_pkg::FMT_BCD_PACKED: begin
          next_state.res.int_data = {56'h0, req.data[7:4], req.data[3:0]};
          next_state.res.bcd_bad = bcd_digit_bad(req.data[7:4]) | bcd_digit_bad(req.data[3:0]);
        end
        ofc_pkg::FMT_BCD_UNPACKED: begin
          // The upper nibble of an unpacked digit is ignored.
          next_state.res.int_data = {60'h0, req.data[3:0]};
          next_state.res.bcd_bad = bcd_digit_bad(req.data[3:0]);
        end
        ofc_pkg::FMT_QUAD: begin
          next_state.res.int_data = req.data[63:0];
          next_state.res.pair_hi = req.pair_hi;
          next_state.res.pair_lo = req.pair_lo;
        end
        ofc_pkg::FMT_BLOCK: begin
          if (req.from_mem && ((req.addr & `OFC_BLOCK_ALIGN_MASK) == 32'h0000_0000)) begin
            next_state.res.blk_data = req.data;
          end else begin
            next_state.res.trap_align = 1'b1;
          end
        end
        default: begin
          next_state.res.trap_unimp = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else if (!rst_sync_n) begin
      state <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign res = state.res;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the registered result against the request one enabled edge earlier.
  default clocking cb @(posedge sys_clk iff clk_en);
  endclocking
  default disable iff (!rst_sync_n);

  a_packed_trap: assert property (req.valid && req.fmt == ofc_pkg::FMT_PACKED
    |=> res.trap_unimp && res.fp.cls == ofc_pkg::CLS_NONE)
    else $error("packed decimal operand did not trap");

  a_class_onehot: assert property (res.valid && (res.fmt == ofc_pkg::FMT_SINGLE
    || res.fmt == ofc_pkg::FMT_DOUBLE || res.fmt == ofc_pkg::FMT_EXT)
    |-> $onehot(res.fp.cls))
    else $error("real operand not in exactly one class");

  a_zero_single: assert property (req.valid && req.fmt == ofc_pkg::FMT_SINGLE
    && req.data[30:0] == 31'h0 |=> res.fp.cls == ofc_pkg::CLS_ZERO
    && res.fp.sign == $past(req.data[31]))
    else $error("single zero misclassified");

  a_nan_double: assert property (req.valid && req.fmt == ofc_pkg::FMT_DOUBLE
    && (&req.data[62:52]) && req.data[51:0] != 52'h0
    |=> res.fp.cls == ofc_pkg::CLS_NAN && res.fp.exp == 15'h7fff)
    else $error("double NaN misclassified");

  a_single_exp: assert property (req.valid && req.fmt == ofc_pkg::FMT_SINGLE
    && req.data[30:23] == 8'h7f |=> res.fp.exp == 15'h3fff
    && res.fp.mant[63:41] == {1'b1, $past(req.data[22:1])})
    else $error("single unpack wrong");

  a_int_widen: assert property (req.valid && req.fmt == ofc_pkg::FMT_WORD
    && req.data[15:0] == 16'h0001 |=> res.fp.exp == 15'h3fff
    && res.fp.mant == 64'h8000_0000_0000_0000 && !res.fp.sign)
    else $error("integer one not widened to extended");

  a_block_align: assert property (req.valid && req.fmt == ofc_pkg::FMT_BLOCK
    |=> res.trap_align == !($past(req.from_mem) && $past(req.addr[3:0]) == 4'h0))
    else $error("block operand alignment check wrong");

  a_field_full: assert property (req.valid && req.fmt == ofc_pkg::FMT_BITFIELD
    && req.bf_width == 5'h00 && req.bf_offset == 5'h00
    |=> res.int_data == {32'h0000_0000, $past(req.data[63:32])})
    else $error("thirty-two bit field wrong");

  a_bcd_packed: assert property (req.valid && req.fmt == ofc_pkg::FMT_BCD_PACKED
    |=> res.int_data[7:0] == $past(req.data[7:0])
    && res.bcd_bad == ($past(req.data[7:4]) > 4'h9 || $past(req.data[3:0]) > 4'h9))
    else $error("packed decimal byte wrong");

  a_ext_fields: assert property (req.valid && req.fmt == ofc_pkg::FMT_EXT
    |=> res.fp.sign == $past(req.data[79]) && res.fp.exp == $past(req.data[78:64])
    && res.fp.mant == $past(req.data[63:0]))
    else $error("extended fields not passed through");

  a_double_exp: assert property (req.valid && req.fmt == ofc_pkg::FMT_DOUBLE
    && req.data[62:52] == 11'h3ff |=> res.fp.exp == 15'h3fff
    && res.fp.mant[63:12] == {1'b1, $past(req.data[51:1])})
    else $error("double unpack wrong");

  a_long_width: assert property (req.valid && req.fmt == ofc_pkg::FMT_LONG
    |=> res.int_data == {{32{$past(req.data[31])}}, $past(req.data[31:0])})
    else $error("long word not sign extended");

  a_quad_pair: assert property (req.valid && req.fmt == ofc_pkg::FMT_QUAD
    |=> res.int_data == $past(req.data[63:0]) && res.pair_hi == $past(req.pair_hi)
    && res.pair_lo == $past(req.pair_lo))
    else $error("quad word or register pair wrong");

endmodule : operand_format_classifier

// *** dv/ofc_pipe_model.sv ***
/*
 Pipeline model that launches operand requests towards the classifier.
 Assumes the bench loads nxt away from the falling edge of sys_clk.
*/
`timescale 1ns/100ps
module ofc_pipe_model (
  input wire logic sys_clk,
  input wire ofc_pkg::ofc_req_s nxt,
  output ofc_pkg::ofc_req_s req
);
  // Idle operand lines show the inverse of the last value, so stale data cannot pass.
  always_ff @(negedge sys_clk) begin
    req <= nxt.valid ? nxt : ofc_pkg::ofc_req_s'({1'b0, ~nxt[$bits(nxt)-2:0]});
  end
endmodule : ofc_pipe_model

// *** dv/operand_format_classifier_tb_top.sv ***
/*
 Self-checking bench of the operand format classifier.
 Assumes the result follows a taken request by one enabled edge.
*/
`timescale 1ns/100ps
module operand_format_classifier_tb_top;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  ofc_pkg::ofc_req_s nxt = '0;
  ofc_pkg::ofc_req_s req;
  ofc_pkg::ofc_res_s res;
  ofc_pkg::ofc_res_s save;
  ofc_pkg::ofc_req_s r;
  int miscompares = 0;
  int num_checks = 0;
  logic [15:0] lf = 16'hd73c;
  logic [31:0] a, b, c, d;

  always #12.5 sys_clk = ~sys_clk;

  ofc_pipe_model i_ofc_pipe_model (.sys_clk(sys_clk), .nxt(nxt), .req(req));
  operand_format_classifier i_operand_format_classifier (.sys_clk(sys_clk), .arst_n(arst_n),
    .clk_en(clk_en), .req(req), .res(res));

  //////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (!ok) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic rnd(output logic [31:0] v);
    for (int i = 0; i < 32; i++) begin
      lf = lfsr(lf);
      v = {v[30:0], lf[0]};
    end
  endtask : rnd

  function automatic ofc_pkg::ofc_cls_e cls_of(input logic ez, input logic eo, input logic fz);
    if (ez) return fz ? ofc_pkg::CLS_ZERO : ofc_pkg::CLS_DENORM;
    if (eo) return fz ? ofc_pkg::CLS_INF : ofc_pkg::CLS_NAN;
    return ofc_pkg::CLS_NORM;
  endfunction : cls_of

  function automatic ofc_pkg::ofc_req_s mk(input ofc_pkg::ofc_fmt_e f, input logic [127:0] dt,
                                           input logic m, input logic [31:0] ad);
    mk = '0;
    mk.valid = 1'b1;
    mk.fmt = f;
    mk.data = dt;
    mk.from_mem = m;
    mk.addr = ad;
  endfunction : mk

  //////////////////////////////////////////////////////////////////////////////
  task automatic verify(input ofc_pkg::ofc_req_s q);
    logic [31:0] iv, m;
    logic [14:0] e;
    logic [63:0] bf;
    ofc_pkg::ofc_cls_e k;
    logic ok;
    int lz, w;
    chk(res.valid === 1'b1 && res.fmt === q.fmt, "valid or format echo");
    ok = q.fmt == ofc_pkg::FMT_PACKED || q.fmt > ofc_pkg::FMT_BLOCK;
    chk(res.trap_unimp === ok, "unimplemented trap");
    case (q.fmt)
      ofc_pkg::FMT_SINGLE: begin
        e = 15'(q.data[30:23]) + 15'h3f80;
        k = cls_of(q.data[30:23] == 0, &q.data[30:23], q.data[22:0] == 0);
        chk(res.fp.cls === k && res.fp.sign === q.data[31], "single class");
        if (k == ofc_pkg::CLS_NORM) begin
          chk(res.fp.exp === e && res.fp.mant === {1'b1, q.data[22:0], 40'h0}, "single");
        end
      end
      ofc_pkg::FMT_DOUBLE: begin
        e = 15'(q.data[62:52]) + 15'h3c00;
        k = cls_of(q.data[62:52] == 0, &q.data[62:52], q.data[51:0] == 0);
        chk(res.fp.cls === k && res.fp.sign === q.data[63], "double class");
        if (k == ofc_pkg::CLS_NORM) begin
          chk(res.fp.exp === e && res.fp.mant === {1'b1, q.data[51:0], 11'h0}, "double");
        end
      end
      ofc_pkg::FMT_EXT: begin
        e = q.data[78:64];
        k = cls_of(e == 0, &e, (e == 0) ? q.data[63:0] == 0 : q.data[62:0] == 0);
        chk(res.fp.cls === k && res.fp.sign === q.data[79], "extended class");
        chk(res.fp.exp === e && res.fp.mant === q.data[63:0], "extended");
      end
      ofc_pkg::FMT_BYTE, ofc_pkg::FMT_WORD, ofc_pkg::FMT_LONG: begin
        iv = (q.fmt == ofc_pkg::FMT_BYTE) ? {{24{q.data[7]}}, q.data[7:0]} :
             (q.fmt == ofc_pkg::FMT_WORD) ? {{16{q.data[15]}}, q.data[15:0]} : q.data[31:0];
        chk(res.int_data === {{32{iv[31]}}, iv}, "integer width");
        m = iv[31] ? -iv : iv;
        lz = 0;
        while (m != 0 && !m[31]) begin
          m = m << 1;
          lz++;
        end
        if (iv == 0) begin
          chk(res.fp.cls === ofc_pkg::CLS_ZERO, "integer zero widen");
        end else begin
          chk(res.fp.cls === ofc_pkg::CLS_NORM && res.fp.sign === iv[31] &&
              res.fp.exp === 15'h401e - 15'(lz) && res.fp.mant === {m, 32'h0},
              "integer widen");
        end
      end
      ofc_pkg::FMT_BLOCK: begin
        ok = q.from_mem && q.addr[3:0] == 0;
        chk(res.trap_align === !ok && res.blk_data === (ok ? q.data : 128'h0), "block");
      end
      ofc_pkg::FMT_BITFIELD: begin
        w = (q.bf_width == 0) ? 32 : q.bf_width;
        bf = (q.data[63:0] >> (64 - q.bf_offset - w)) & ((64'h1 << w) - 64'h1);
        chk(res.int_data === bf, "bit field");
      end
      ofc_pkg::FMT_BCD_PACKED: begin
        chk(res.bcd_bad === (q.data[7:4] > 9 || q.data[3:0] > 9) &&
            res.int_data === {56'h0, q.data[7:0]}, "packed decimal");
      end
      ofc_pkg::FMT_BCD_UNPACKED: begin
        chk(res.bcd_bad === (q.data[3:0] > 9) &&
            res.int_data === {60'h0, q.data[3:0]}, "unpacked decimal");
      end
      ofc_pkg::FMT_QUAD: begin
        chk(res.int_data === q.data[63:0] && res.pair_hi === q.pair_hi &&
            res.pair_lo === q.pair_lo, "quad word");
      end
      default: begin
      end
    endcase
  endtask : verify

  task automatic issue(input ofc_pkg::ofc_req_s q);
    @(posedge sys_clk);
    nxt = q;
    @(posedge sys_clk);
    nxt.valid = 1'b0;
    @(negedge sys_clk);
    verify(q);
    @(negedge sys_clk);
    chk(res.valid === 1'b0, "valid drops after one cycle");
  endtask : issue

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge sys_clk);
    chk(res === '0, "result clear in reset");
    arst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(res.valid === 1'b0, "no result after release");
    $display("reset test done");
    issue(mk(ofc_pkg::FMT_SINGLE, 32'h3f80_0000, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_SINGLE, 32'h8000_0000, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_SINGLE, 32'h7f80_0000, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_SINGLE, 32'h7fc0_0000, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_SINGLE, 32'h0000_0001, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_DOUBLE, 64'hfff0_0000_0000_0000, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_DOUBLE, 64'h0000_0000_0000_0001, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_DOUBLE, 64'h7ff0_0000_0000_0001, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_DOUBLE, 64'h3ff0_0000_0000_0001, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_EXT, 80'h7fff_8000_0000_0000_0000, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_EXT, 80'h0000_0000_0000_0000_0001, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_LONG, 32'h8000_0000, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_BYTE, 8'h80, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_WORD, 16'h0000, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_WORD, 16'h0001, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_PACKED, 96'h1, 1'b1, 32'h0));
    issue(mk(ofc_pkg::ofc_fmt_e'(4'hf), 32'h1, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_BLOCK, ~128'h0, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_BLOCK, ~128'h0, 1'b1, 32'h0008));
    issue(mk(ofc_pkg::FMT_BLOCK, ~128'h0, 1'b1, 32'h0010));
    issue(mk(ofc_pkg::FMT_BCD_PACKED, 8'h9a, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_BCD_UNPACKED, 8'hf9, 1'b0, 32'h0));
    issue(mk(ofc_pkg::FMT_BITFIELD, ~64'h0, 1'b0, 32'h0));
    $display("corner test done");
    for (int n = 0; n < 300; n++) begin
      rnd(a);
      rnd(b);
      rnd(c);
      rnd(d);
      r = mk(ofc_pkg::ofc_fmt_e'(4'(a % 12)), {a, b, c, d}, b[0], b[1] ? {c[31:4], 4'h0} : c);
      r.bf_offset = d[4:0];
      r.bf_width = c[9:5];
      r.pair_hi = a[6:4];
      r.pair_lo = a[9:7];
      issue(r);
    end
    $display("random test done");
    // A reset in mid-run must clear a result that still holds earlier data.
    arst_n = 1'b0;
    @(negedge sys_clk);
    chk(res === '0, "result cleared by reset in mid-run");
    arst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(res === '0, "no result after second release");
    issue(mk(ofc_pkg::FMT_LONG, 32'h8000_0000, 1'b0, 32'h0));
    $display("second reset test done");
    // The request stands while the enable is low; it may only be taken once enabled.
    save = res;
    @(posedge sys_clk);
    r = mk(ofc_pkg::FMT_LONG, 32'h1, 1'b0, 32'h0);
    nxt = r;
    @(negedge sys_clk);
    clk_en = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(res === save, "result holds with enable low");
    clk_en = 1'b1;
    @(posedge sys_clk);
    nxt.valid = 1'b0;
    @(negedge sys_clk);
    verify(r);
    $display("hold test done");
    results;
  end

  initial begin
    #1000000;
    miscompares++;
    results;
  end
endmodule : operand_format_classifier_tb_top
